// ==== gpio_pkg.sv ====
package gpio_pkg;

    localparam int PORT_A_WIDTH = 5;
    localparam int PORT_B_WIDTH = 8;
    localparam int ADDR_WIDTH   = 10;
    localparam int DATA_WIDTH   = 32;

    // register indices; the byte address is four times the index
    localparam logic [7:0] PORT_A_PINS_IDX       = 8'h05;
    localparam logic [7:0] PORT_B_PINS_IDX       = 8'h06;
    localparam logic [7:0] INTERRUPT_CONTROL_IDX = 8'h0B;
    localparam logic [7:0] OPTION_IDX            = 8'h81;
    localparam logic [7:0] PORT_A_DIRECTION_IDX  = 8'h85;
    localparam logic [7:0] PORT_B_DIRECTION_IDX  = 8'h86;
    localparam logic [7:0] ANALOG_PIN_CONFIG_IDX = 8'h9F;

    localparam logic [9:0] PORT_A_PINS_ADDR       = {PORT_A_PINS_IDX, 2'b00};
    localparam logic [9:0] PORT_B_PINS_ADDR       = {PORT_B_PINS_IDX, 2'b00};
    localparam logic [9:0] INTERRUPT_CONTROL_ADDR = {INTERRUPT_CONTROL_IDX, 2'b00};
    localparam logic [9:0] OPTION_ADDR            = {OPTION_IDX, 2'b00};
    localparam logic [9:0] PORT_A_DIRECTION_ADDR  = {PORT_A_DIRECTION_IDX, 2'b00};
    localparam logic [9:0] PORT_B_DIRECTION_ADDR  = {PORT_B_DIRECTION_IDX, 2'b00};
    localparam logic [9:0] ANALOG_PIN_CONFIG_ADDR = {ANALOG_PIN_CONFIG_IDX, 2'b00};

    // field positions
    localparam int PULLUP_DISABLE_N_BIT = 7;
    localparam int PORT_CHANGE_FLAG_BIT = 0;
    localparam int TIMER_CLOCK_BIT      = 4;
    localparam int EXT_IRQ_BIT          = 0;
    localparam int PROG_CLOCK_BIT       = 6;
    localparam int PROG_DATA_BIT        = 7;
    localparam int CHANGE_LO_BIT        = 4;

    // values after reset
    localparam logic [4:0] PORT_A_DIRECTION_RST  = 5'h1F;
    localparam logic [4:0] PORT_A_LATCH_RST      = 5'h00;
    localparam logic [7:0] PORT_B_DIRECTION_RST  = 8'hFF;
    localparam logic [7:0] PORT_B_LATCH_RST      = 8'h00;
    localparam logic [7:0] OPTION_RST            = 8'hFF;
    localparam logic [1:0] ANALOG_PIN_CONFIG_RST = 2'h0;
    localparam logic [7:0] INTERRUPT_CONTROL_RST = 8'h00;

    // analog select field codes
    localparam logic [1:0] ANALOG_ALL_FOUR = 2'h0;
    localparam logic [1:0] ANALOG_FOUR_REF = 2'h1;
    localparam logic [1:0] ANALOG_LOW_TWO  = 2'h2;
    localparam logic [1:0] ANALOG_NONE     = 2'h3;

endpackage

// ==== pin_sync.sv ====
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             sys_clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] stage1_reg;

    // the first stage feeds only the second stage
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            stage1_reg <= '0;
            sync_o     <= '0;
        end else begin
            stage1_reg <= async_i;
            sync_o     <= stage1_reg;
        end
    end

endmodule

// ==== dual_gpio_port.sv ====
// How it works
// - port A: five latch bits, upper three zero
// - port A direction one tristates, zero drives
// - port A read gives pins, write latch
// - writes sample pins, modify, store latch
// - port A bit 4 open drain, timer clock
// - analog pins after reset read zero
// - two-bit analog select field, resets 00
// - port A direction resets ones, latch zero
// - port B eight bits, direction per pin
// - shared active-low pull-up enable, option bit7
// - pull-up off when pin is output
// - pull-ups disabled after reset
// - only upper four input pins compared
// - mismatches ORed into change flag bit0
// - change event wakes device from sleep
// - mismatch keeps setting flag until port B read or write
// - port B bit 0 is external interrupt
// - bits 6,7 serve serial programming
// - enabled peripheral takes pin from GPIO; only programming mode does, irq, timer and analog pins keep GPIO drive
// - flag sets regardless of enable bits
`timescale 1ns/1ps
module dual_gpio_port
    import gpio_pkg::*;
(
    input  wire logic                    sys_clk_i,
    input  wire logic                    rst_i,
    input  wire logic [ADDR_WIDTH-1:0]   avs_address_i,
    input  wire logic                    avs_read_i,
    input  wire logic                    avs_write_i,
    input  wire logic [DATA_WIDTH-1:0]   avs_writedata_i,
    input  wire logic [3:0]              avs_byteenable_i,
    output logic      [DATA_WIDTH-1:0]   avs_readdata_o,
    output logic                         avs_waitrequest_o,
    input  wire logic [PORT_A_WIDTH-1:0] port_a_in_i,
    output logic      [PORT_A_WIDTH-1:0] port_a_out_o,
    output logic      [PORT_A_WIDTH-1:0] port_a_oe_o,
    input  wire logic [PORT_B_WIDTH-1:0] port_b_in_i,
    output logic      [PORT_B_WIDTH-1:0] port_b_out_o,
    output logic      [PORT_B_WIDTH-1:0] port_b_oe_o,
    output logic      [PORT_B_WIDTH-1:0] port_b_pullup_o,
    input  wire logic                    prog_mode_i,
    output logic                         timer_clock_o,
    output logic                         ext_irq_pin_o,
    output logic                         prog_clock_o,
    output logic                         prog_data_o,
    output logic                         wake_o
);

    logic [PORT_A_WIDTH-1:0] pa_sync;
    logic [PORT_B_WIDTH-1:0] pb_sync;
    logic [PORT_A_WIDTH-1:0] port_a_latch_reg;
    logic [PORT_A_WIDTH-1:0] port_a_direction_reg;
    logic [PORT_B_WIDTH-1:0] port_b_latch_reg;
    logic [PORT_B_WIDTH-1:0] port_b_direction_reg;
    logic [7:0]              option_reg;
    logic [1:0]              analog_pin_config_reg;
    logic [7:0]              interrupt_control_reg;
    logic [3:0]              snapshot_reg;
    logic                    ack_reg;
    logic                    wr_go;
    logic                    rd_go;
    logic                    lane0;
    logic [3:0]              analog_mask;
    logic [PORT_A_WIDTH-1:0] pa_digital;
    logic [3:0]              change_mismatch;
    logic                    mismatch;
    logic [PORT_B_WIDTH-1:0] pb_gpio_mask;
    logic [7:0]              rd_mux;
    logic [7:0]              wdata;

    pin_sync #(
        .WIDTH (PORT_A_WIDTH)
    ) u_sync_a (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .async_i   (port_a_in_i),
        .sync_o    (pa_sync)
    );

    pin_sync #(
        .WIDTH (PORT_B_WIDTH)
    ) u_sync_b (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .async_i   (port_b_in_i),
        .sync_o    (pb_sync)
    );

    // one wait cycle per access; the request is taken on the acking edge
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_reg;
    assign wr_go = avs_write_i & ack_reg;
    assign rd_go = avs_read_i & ack_reg;
    assign lane0 = avs_byteenable_i[0];
    assign wdata = avs_writedata_i[7:0];

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (avs_read_i | avs_write_i) & ~ack_reg;
        end
    end

    // analog pins, chosen by the select field
    always_comb begin
        unique case (analog_pin_config_reg)
            ANALOG_ALL_FOUR: analog_mask = 4'hF;
            ANALOG_FOUR_REF: analog_mask = 4'hF;
            ANALOG_LOW_TWO:  analog_mask = 4'h3;
            ANALOG_NONE:     analog_mask = 4'h0;
        endcase
    end

    assign pa_digital = pa_sync & {1'b1, ~analog_mask};

    // programming takes bits 6 and 7
    assign pb_gpio_mask = prog_mode_i ? 8'h3F : 8'hFF;

    always_comb begin
        unique case (avs_address_i)
            PORT_A_PINS_ADDR:       rd_mux = {3'h0, pa_digital};
            PORT_A_DIRECTION_ADDR:  rd_mux = {3'h0, port_a_direction_reg};
            ANALOG_PIN_CONFIG_ADDR: rd_mux = {6'h00, analog_pin_config_reg};
            PORT_B_PINS_ADDR:       rd_mux = pb_sync;
            PORT_B_DIRECTION_ADDR:  rd_mux = port_b_direction_reg;
            OPTION_ADDR:            rd_mux = option_reg;
            INTERRUPT_CONTROL_ADDR: rd_mux = interrupt_control_reg;
            default:                rd_mux = 8'h00;
        endcase
    end

    // reads show pins; unmapped reads give zero
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            avs_readdata_o <= '0;
        end else if (avs_read_i && !ack_reg) begin
            avs_readdata_o <= {24'h000000, rd_mux};
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            port_a_latch_reg <= PORT_A_LATCH_RST;
        end else if (wr_go && avs_address_i == PORT_A_PINS_ADDR) begin
            port_a_latch_reg <= lane0 ? wdata[PORT_A_WIDTH-1:0] : pa_sync;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            port_a_direction_reg <= PORT_A_DIRECTION_RST;
        end else if (wr_go && lane0 && avs_address_i == PORT_A_DIRECTION_ADDR) begin
            port_a_direction_reg <= wdata[PORT_A_WIDTH-1:0];
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            analog_pin_config_reg <= ANALOG_PIN_CONFIG_RST;
        end else if (wr_go && lane0 && avs_address_i == ANALOG_PIN_CONFIG_ADDR) begin
            analog_pin_config_reg <= wdata[1:0];
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            port_b_latch_reg <= PORT_B_LATCH_RST;
        end else if (wr_go && avs_address_i == PORT_B_PINS_ADDR) begin
            port_b_latch_reg <= lane0 ? wdata : pb_sync;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            port_b_direction_reg <= PORT_B_DIRECTION_RST;
        end else if (wr_go && lane0 && avs_address_i == PORT_B_DIRECTION_ADDR) begin
            port_b_direction_reg <= wdata;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            option_reg <= OPTION_RST;
        end else if (wr_go && lane0 && avs_address_i == OPTION_ADDR) begin
            option_reg <= wdata;
        end
    end

    // snapshot taken on each port B read
    // and on each port B write
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            snapshot_reg <= 4'h0;
        end else if ((rd_go || wr_go) && avs_address_i == PORT_B_PINS_ADDR) begin
            snapshot_reg <= pb_sync[7:CHANGE_LO_BIT];
        end
    end

    assign change_mismatch = (pb_sync[7:CHANGE_LO_BIT] ^ snapshot_reg) & port_b_direction_reg[7:CHANGE_LO_BIT];
    assign mismatch        = |change_mismatch;

    // set wins over a software clear
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            interrupt_control_reg <= INTERRUPT_CONTROL_RST;
        end else begin
            if (wr_go && lane0 && avs_address_i == INTERRUPT_CONTROL_ADDR) begin
                interrupt_control_reg <= wdata;
            end
            if (mismatch) begin
                interrupt_control_reg[PORT_CHANGE_FLAG_BIT] <= 1'b1;
            end
        end
    end

    // flag level doubles as wake request
    assign wake_o = interrupt_control_reg[PORT_CHANGE_FLAG_BIT];

    // drivers follow direction; analog pins rely on software tristate
    assign port_a_out_o = {1'b0, port_a_latch_reg[3:0]};
    // open drain: bit 4 only pulls low
    assign port_a_oe_o  = {~port_a_direction_reg[TIMER_CLOCK_BIT] & ~port_a_latch_reg[TIMER_CLOCK_BIT],
                           ~port_a_direction_reg[3:0]};
    assign timer_clock_o = pa_sync[TIMER_CLOCK_BIT];

    assign port_b_out_o = port_b_latch_reg;
    assign port_b_oe_o  = ~port_b_direction_reg & pb_gpio_mask;

    assign port_b_pullup_o = {PORT_B_WIDTH{~option_reg[PULLUP_DISABLE_N_BIT]}} & port_b_direction_reg;

    assign ext_irq_pin_o = pb_sync[EXT_IRQ_BIT];
    assign prog_clock_o  = pb_sync[PROG_CLOCK_BIT];
    assign prog_data_o   = pb_sync[PROG_DATA_BIT];

    property p_pa_read_upper;
        @(posedge sys_clk_i) disable iff (rst_i)
        (rd_go && avs_address_i == PORT_A_PINS_ADDR) |-> avs_readdata_o[7:5] == 3'h0;
    endproperty
    a_pa_read_upper: assert property (p_pa_read_upper) else $error("port a upper bits not zero");

    property p_pa_drive;
        @(posedge sys_clk_i) disable iff (rst_i)
        !port_a_direction_reg[0] |-> port_a_oe_o[0] && port_a_out_o[0] == port_a_latch_reg[0];
    endproperty
    a_pa_drive: assert property (p_pa_drive) else $error("port a bit0 not driven from latch");

    property p_pa_read_pins;
        @(posedge sys_clk_i) disable iff (rst_i)
        (avs_read_i && !ack_reg && avs_address_i == PORT_A_PINS_ADDR && analog_pin_config_reg == ANALOG_NONE)
        |=> avs_readdata_o[4:0] == $past(pa_sync);
    endproperty
    a_pa_read_pins: assert property (p_pa_read_pins) else $error("port a read not pin state");

    property p_open_drain;
        @(posedge sys_clk_i) disable iff (rst_i)
        port_a_oe_o[TIMER_CLOCK_BIT] |-> !port_a_out_o[TIMER_CLOCK_BIT] && !port_a_latch_reg[TIMER_CLOCK_BIT];
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("bit 4 drives high");

    property p_analog_zero;
        @(posedge sys_clk_i) disable iff (rst_i)
        (avs_read_i && !ack_reg && avs_address_i == PORT_A_PINS_ADDR && analog_pin_config_reg == ANALOG_ALL_FOUR)
        |=> avs_readdata_o[3:0] == 4'h0;
    endproperty
    a_analog_zero: assert property (p_analog_zero) else $error("analog pin read nonzero");

    property p_pb_oe;
        @(posedge sys_clk_i) disable iff (rst_i)
        !prog_mode_i |-> port_b_oe_o == ~port_b_direction_reg;
    endproperty
    a_pb_oe: assert property (p_pb_oe) else $error("port b enable mismatches direction");

    property p_pullup_output;
        @(posedge sys_clk_i) disable iff (rst_i)
        (port_b_pullup_o & ~port_b_direction_reg) == 8'h00
        && (port_b_pullup_o == 8'h00 || !option_reg[PULLUP_DISABLE_N_BIT]);
    endproperty
    a_pullup_output: assert property (p_pullup_output) else $error("pull-up on output pin");

    property p_mismatch_sets;
        @(posedge sys_clk_i) disable iff (rst_i)
        mismatch |=> interrupt_control_reg[PORT_CHANGE_FLAG_BIT] && wake_o;
    endproperty
    a_mismatch_sets: assert property (p_mismatch_sets) else $error("mismatch did not set flag");

    property p_clear_blocked;
        @(posedge sys_clk_i) disable iff (rst_i)
        (wr_go && avs_address_i == INTERRUPT_CONTROL_ADDR && mismatch) |=> interrupt_control_reg[0];
    endproperty
    a_clear_blocked: assert property (p_clear_blocked) else $error("flag cleared during mismatch");

    property p_write_snapshot;
        @(posedge sys_clk_i) disable iff (rst_i)
        (wr_go && avs_address_i == PORT_B_PINS_ADDR) |=> snapshot_reg == $past(pb_sync[7:4]);
    endproperty
    a_write_snapshot: assert property (p_write_snapshot) else $error("write did not refresh snapshot");

    property p_prog_release;
        @(posedge sys_clk_i) disable iff (rst_i)
        prog_mode_i |-> port_b_oe_o[7:6] == 2'h0;
    endproperty
    a_prog_release: assert property (p_prog_release) else $error("programming pins still driven");

    property p_latch_write;
        @(posedge sys_clk_i) disable iff (rst_i)
        (wr_go && lane0 && avs_address_i == PORT_A_PINS_ADDR)
        |=> port_a_latch_reg == $past(wdata[PORT_A_WIDTH-1:0]);
    endproperty
    a_latch_write: assert property (p_latch_write) else $error("port a write missed latch");

    property p_rmw_sample;
        @(posedge sys_clk_i) disable iff (rst_i)
        (wr_go && !lane0 && avs_address_i == PORT_A_PINS_ADDR) |=> port_a_latch_reg == $past(pa_sync);
    endproperty
    a_rmw_sample: assert property (p_rmw_sample) else $error("unwritten lane did not keep pins");

    property p_pullup_on;
        @(posedge sys_clk_i) disable iff (rst_i)
        !option_reg[PULLUP_DISABLE_N_BIT] |-> port_b_pullup_o == port_b_direction_reg;
    endproperty
    a_pullup_on: assert property (p_pullup_on) else $error("pull-up missing on input pin");

    property p_flag_clear;
        @(posedge sys_clk_i) disable iff (rst_i)
        (wr_go && lane0 && avs_address_i == INTERRUPT_CONTROL_ADDR && !wdata[PORT_CHANGE_FLAG_BIT] && !mismatch)
        |=> !interrupt_control_reg[PORT_CHANGE_FLAG_BIT];
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag clear without mismatch ignored");

endmodule

// ==== board_model.sv ====
`timescale 1ns/1ps
module board_model
    import gpio_pkg::*;
(
    input  wire logic                    sys_clk_i,
    input  wire logic [PORT_A_WIDTH-1:0] a_out_i,
    input  wire logic [PORT_A_WIDTH-1:0] a_oe_i,
    input  wire logic [PORT_A_WIDTH-1:0] a_ext_i,
    input  wire logic [PORT_A_WIDTH-1:0] a_ext_en_i,
    input  wire logic [PORT_B_WIDTH-1:0] b_out_i,
    input  wire logic [PORT_B_WIDTH-1:0] b_oe_i,
    input  wire logic [PORT_B_WIDTH-1:0] b_pullup_i,
    input  wire logic [PORT_B_WIDTH-1:0] b_ext_i,
    input  wire logic [PORT_B_WIDTH-1:0] b_ext_en_i,
    output logic      [PORT_A_WIDTH-1:0] a_pin_o,
    output logic      [PORT_B_WIDTH-1:0] b_pin_o
);
    logic float_q = 1'b0;

    // a floating line wanders so that a stale level never passes for a drive
    always_ff @(posedge sys_clk_i) begin
        float_q <= ~float_q;
    end

    always_comb begin
        for (int i = 0; i < PORT_A_WIDTH; i++) begin
            // the open-drain timer clock pin has a pull-up resistor on the board
            a_pin_o[i] = a_oe_i[i] ? a_out_i[i] : a_ext_en_i[i] ? a_ext_i[i] :
                         (i == TIMER_CLOCK_BIT) ? 1'b1 : float_q;
        end
        for (int i = 0; i < PORT_B_WIDTH; i++) begin
            b_pin_o[i] = b_oe_i[i] ? b_out_i[i] : b_ext_en_i[i] ? b_ext_i[i] : b_pullup_i[i] ? 1'b1 : float_q;
        end
    end
endmodule

// ==== dual_gpio_port_tb.sv ====
`timescale 1ns/1ps
module dual_gpio_port_tb
    import gpio_pkg::*;
;
    logic                    clk;
    logic                    rst;
    logic [ADDR_WIDTH-1:0]   addr;
    logic                    rd;
    logic                    wr;
    logic [DATA_WIDTH-1:0]   wdata;
    logic [3:0]              be;
    logic [DATA_WIDTH-1:0]   rdata;
    logic                    wreq;
    logic [PORT_A_WIDTH-1:0] pa_in, pa_out, pa_oe, a_ext, a_ext_en;
    logic [PORT_B_WIDTH-1:0] pb_in, pb_out, pb_oe, pb_pu, b_ext, b_ext_en;
    logic                    prog_mode;
    logic                    tmr_clk, irq_pin, prog_clk, prog_dat, wake;
    int                      error_cnt = 0;
    int                      comparisons = 0;

    dual_gpio_port uut (
        .sys_clk_i(clk), .rst_i(rst), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
        .port_a_in_i(pa_in), .port_a_out_o(pa_out), .port_a_oe_o(pa_oe),
        .port_b_in_i(pb_in), .port_b_out_o(pb_out), .port_b_oe_o(pb_oe), .port_b_pullup_o(pb_pu),
        .prog_mode_i(prog_mode), .timer_clock_o(tmr_clk), .ext_irq_pin_o(irq_pin),
        .prog_clock_o(prog_clk), .prog_data_o(prog_dat), .wake_o(wake)
    );

    board_model board (
        .sys_clk_i(clk), .a_out_i(pa_out), .a_oe_i(pa_oe), .a_ext_i(a_ext), .a_ext_en_i(a_ext_en),
        .b_out_i(pb_out), .b_oe_i(pb_oe), .b_pullup_i(pb_pu), .b_ext_i(b_ext), .b_ext_en_i(b_ext_en),
        .a_pin_o(pa_in), .b_pin_o(pb_in)
    );

    task automatic report_and_stop();
        $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // request held until waitrequest is seen low at a rising edge; outputs sampled at the next falling edge
    task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [3:0] b,
                       output logic [31:0] q);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        be <= b;
        rd <= ~w;
        wr <= w;
        do @(posedge clk); while (wreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(negedge clk);
    endtask

    task automatic wr_reg(input logic [9:0] a, input logic [31:0] d, input logic [3:0] b = 4'hF);
        logic [31:0] q;
        bus(1'b1, a, d, b, q);
    endtask

    task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 4'hF, q);
        check(q, exp);
    endtask

    // pins pass two synchronising flops, so let them settle before looking
    task automatic set_b(input logic [7:0] v);
        @(posedge clk);
        b_ext <= v;
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic t_reset();
        check({pa_out, pa_oe, pb_out, pb_oe}, 26'h0);
        check(pb_pu, 8'h00);
        rd_chk(PORT_A_DIRECTION_ADDR, 32'h1F);
        rd_chk(PORT_B_DIRECTION_ADDR, 32'hFF);
        rd_chk(ANALOG_PIN_CONFIG_ADDR, 32'h0);
        rd_chk(OPTION_ADDR, 32'hFF);
        rd_chk(PORT_A_PINS_ADDR, 32'h10);
        wr_reg(10'h3FC, 32'hFF);
        rd_chk(10'h3FC, 32'h0);
    endtask

    // direction stays all inputs while pins are analog
    task automatic t_analog();
        logic [4:0] exp [4] = '{5'h10, 5'h10, 5'h1C, 5'h1F};
        for (int c = 0; c < 4; c++) begin
            wr_reg(ANALOG_PIN_CONFIG_ADDR, 32'(c));
            rd_chk(ANALOG_PIN_CONFIG_ADDR, 32'(c));
            rd_chk(PORT_A_PINS_ADDR, 32'(exp[c]));
        end
    endtask

    task automatic t_port_a();
        wr_reg(PORT_A_PINS_ADDR, 32'hEA);
        wr_reg(PORT_A_DIRECTION_ADDR, 32'h00);
        check(pa_out, 5'h0A);
        check(pa_oe, 5'h1F);
        // the new drive needs two flops before a read can see it
        repeat (3) @(negedge clk);
        rd_chk(PORT_A_PINS_ADDR, 32'h0A);
        @(posedge clk);
        a_ext_en <= 5'h0F;
        wr_reg(PORT_A_PINS_ADDR, 32'h1A);
        repeat (3) @(negedge clk);
        check({pa_out[4], pa_oe[4], tmr_clk}, 3'b001);
        wr_reg(PORT_A_DIRECTION_ADDR, 32'h1F);
        @(posedge clk);
        a_ext <= 5'h05;
        repeat (3) @(negedge clk);
        wr_reg(PORT_A_PINS_ADDR, 32'h00, 4'h0);
        wr_reg(PORT_A_DIRECTION_ADDR, 32'h00);
        check({pa_out, pa_oe}, 10'h0AF);
        wr_reg(PORT_A_DIRECTION_ADDR, 32'h1F);
    endtask

    task automatic t_port_b();
        wr_reg(PORT_B_DIRECTION_ADDR, 32'hF0);
        wr_reg(PORT_B_PINS_ADDR, 32'hA5);
        wr_reg(OPTION_ADDR, 32'h7F);
        check({pb_out, pb_oe}, 16'hA50F);
        check(pb_pu, 8'hF0);
        set_b(8'h40);
        check({irq_pin, prog_clk, prog_dat}, 3'b110);
        wr_reg(PORT_B_DIRECTION_ADDR, 32'h00);
        check(pb_pu, 8'h00);
        @(posedge clk);
        prog_mode <= 1'b1;
        @(negedge clk);
        check(pb_oe, 8'h3F);
        @(posedge clk);
        prog_mode <= 1'b0;
        wr_reg(OPTION_ADDR, 32'hFF);
        wr_reg(PORT_B_DIRECTION_ADDR, 32'hFF);
        check(pb_pu, 8'h00);
    endtask

    task automatic t_change();
        set_b(8'h30);
        rd_chk(PORT_B_PINS_ADDR, 32'h30);
        wr_reg(INTERRUPT_CONTROL_ADDR, 32'h0);
        check(wake, 1'b0);
        set_b(8'h3F);
        check(wake, 1'b0);
        set_b(8'h1F);
        check(wake, 1'b1);
        wr_reg(INTERRUPT_CONTROL_ADDR, 32'h0);
        rd_chk(INTERRUPT_CONTROL_ADDR, 32'h1);
        wr_reg(PORT_B_PINS_ADDR, 32'h10);
        wr_reg(INTERRUPT_CONTROL_ADDR, 32'h0);
        check(wake, 1'b0);
        set_b(8'h0F);
        check(wake, 1'b1);
        rd_chk(PORT_B_PINS_ADDR, 32'h0F);
        wr_reg(INTERRUPT_CONTROL_ADDR, 32'h0);
        rd_chk(INTERRUPT_CONTROL_ADDR, 32'h0);
        wr_reg(PORT_B_DIRECTION_ADDR, 32'hEF);
        repeat (4) @(negedge clk);
        check({pb_in[4], wake}, 2'b10);
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        rst = 1'b1;
        addr = '0;
        rd = 1'b0;
        wr = 1'b0;
        wdata = '0;
        be = 4'hF;
        a_ext = 5'h1F;
        a_ext_en = 5'h1F;
        b_ext = 8'h00;
        b_ext_en = 8'hFF;
        prog_mode = 1'b0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        t_reset();
        t_analog();
        t_port_a();
        t_port_b();
        t_change();
        report_and_stop();
    end

    // whole sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        report_and_stop();
    end
endmodule
